/* swt_pkg.sv */
package swt_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [13:0] IDX_EVENT_FLAGS = 14'hf01;
  localparam logic [13:0] IDX_EVENT_MASKS = 14'hf11;
  localparam logic [13:0] IDX_HUNDREDTHS  = 14'hf22;
  localparam logic [13:0] IDX_TENTHS      = 14'hf23;
  localparam logic [13:0] IDX_CONTROL     = 14'hf77;
  localparam logic [13:0] IDX_IRQ_STATUS  = 14'hf30;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          BIT_TENTHS_EVENT  = 0;
  localparam int          BIT_SECONDS_EVENT = 1;
  localparam int          BIT_RUN           = 0;
  localparam int          BIT_CLEAR         = 1;
  localparam logic [1:0]  RST_FLAGS         = 2'h0;
  localparam logic [1:0]  RST_MASKS         = 2'h0;
  localparam logic [1:0]  RST_IRQ_STATUS    = 2'h0;
  localparam logic        RST_RUN           = 1'h0;
  localparam logic [3:0]  RST_DIGIT         = 4'h0;

  // ---------------------------------------------------------------
  // count pattern
  // ---------------------------------------------------------------
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [1:0]  STEP_SHORT    = 2'h2;
  localparam logic [1:0]  STEP_LONG     = 2'h3;
  localparam logic [5:0]  IV_SHORT      = 6'h19;
  localparam logic [5:0]  IV_LONG       = 6'h1a;
  // bit n set: tenths interval n is a long (26 tick) one
  localparam logic [9:0]  LONG_IV_MAP   = 10'h2d6;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_PERIOD_PS  = 5000;
  localparam longint TICK_PERIOD_PS = 64'd3906250000;
  localparam int     TICK_CYCLES    = int'(TICK_PERIOD_PS / CLK_PERIOD_PS);

endpackage : swt_pkg

/* swt_tick_div.sv */
`timescale 1ns/1ps
module swt_tick_div
  import swt_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  output logic      o_tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } swt_div_t;

  swt_div_t st;
  swt_div_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = (st.cnt == 32'(DIV - 1));
    if (next_st.tick) begin
      next_st.cnt = 32'h0;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

endmodule : swt_tick_div

/* swt_bcd_digit.sv */
`timescale 1ns/1ps
module swt_bcd_digit
  import swt_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_clear,
  input  wire logic       i_inc,
  output logic [3:0]      o_value,
  output logic            o_wrap
);

  typedef struct packed {
    logic [3:0] value;
  } swt_digit_t;

  swt_digit_t st;
  swt_digit_t next_st;

  // clear beats a coincident increment, so no wrap is reported then
  always_comb begin
    next_st = st;
    o_wrap  = i_inc && !i_clear && (st.value == DIGIT_MAX);
    if (i_clear) begin
      next_st.value = RST_DIGIT;
    end else if (o_wrap) begin
      next_st.value = RST_DIGIT;
    end else if (i_inc) begin
      next_st.value = st.value + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st.value <= RST_DIGIT;
    end else begin
      st <= next_st;
    end
  end

  assign o_value = st.value;

endmodule : swt_bcd_digit

/* swt_stopwatch.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// Functional notes
// - two cascaded BCD digits, each 0..9
// - hundredths steps every 2 or 3 ticks
// - tenths intervals of 25 or 26 ticks
// - digit wrap nine to zero sets flag
// - flags set regardless of mask bits
// - mask bit 1 enables, readable
// - masks cleared on reset
// - flags cleared on reset, writes ignored
// - clear strobe zeroes digits, reads zero
// - clear write also sets run from bit 0
// - run bit starts and halts counting
// - run bit cleared on reset
// - digits readable, read-only, reset zero
// - reading flags clears the flags read
module swt_stopwatch
  import swt_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [15:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_tenths_irq,
  output logic             o_seconds_irq,
  output logic             o_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  flags;
    logic [1:0]  masks;
    logic [1:0]  irq_status;
    logic        run;
    logic [1:0]  step_cnt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tenths_irq;
    logic        seconds_irq;
    logic        irq;
  } swt_state_t;

  swt_state_t st;
  swt_state_t next_st;

  logic        tick;
  logic [3:0]  hund;
  logic [3:0]  tenths;
  logic        hund_wrap;
  logic        tenths_wrap;
  logic        hund_inc;
  logic        clear;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic [13:0] idx;
  logic        aligned;
  logic [1:0]  spacing;
  logic [1:0]  events;
  logic [1:0]  rd_clear;

  // ---------------------------------------------------------------
  // base tick and digits
  // ---------------------------------------------------------------
  swt_tick_div #(
    .DIV (TICK_DIV)
  ) u_tick (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  swt_bcd_digit u_hund (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_clear (clear),
    .i_inc   (hund_inc),
    .o_value (hund),
    .o_wrap  (hund_wrap)
  );

  // tenths digit counts hundredths wraps
  swt_bcd_digit u_tenths (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_clear (clear),
    .i_inc   (hund_wrap),
    .o_value (tenths),
    .o_wrap  (tenths_wrap)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    idx     = i_paddr[15:2];
    aligned = (i_paddr[1:0] == 2'h0);
    setup   = i_psel && !i_penable;
    access  = i_psel && i_penable && st.pready;
    wr      = access && i_pwrite;
    rd      = access && !i_pwrite;

    // odd steps long; step zero also long in a long tenths interval
    if (hund[0] || (LONG_IV_MAP[tenths] && (hund == 4'h0))) begin
      spacing = STEP_LONG;
    end else begin
      spacing = STEP_SHORT;
    end
    clear    = wr && aligned && (idx == IDX_CONTROL) && i_pwdata[BIT_CLEAR];
    hund_inc = tick && st.run && (st.step_cnt == 2'(spacing - 2'h1));

    // prescaler restarts on clear so the first step is a full one
    if (clear) begin
      next_st.step_cnt = 2'h0;
    end else if (hund_inc) begin
      next_st.step_cnt = 2'h0;
    end else if (tick && st.run) begin
      next_st.step_cnt = st.step_cnt + 2'h1;
    end

    events = 2'h0;
    events[BIT_TENTHS_EVENT]  = hund_wrap;
    events[BIT_SECONDS_EVENT] = tenths_wrap;

    // read-clear acts only on bits captured into the read data
    rd_clear = 2'h0;
    if (rd && aligned && (idx == IDX_EVENT_FLAGS)) begin
      rd_clear = st.prdata[1:0];
    end
    next_st.flags = (st.flags & ~rd_clear) | events;

    if (wr && aligned) begin
      unique case (idx)
        IDX_EVENT_MASKS: next_st.masks = i_pwdata[1:0];
        IDX_CONTROL:     next_st.run   = i_pwdata[BIT_RUN];
        IDX_IRQ_STATUS:  next_st.irq_status = st.irq_status & ~i_pwdata[1:0];
        default: ;
      endcase
    end
    next_st.irq_status = next_st.irq_status | events;

    // ---- apb: decode in setup, answer in the access cycle
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    if (setup) begin
      next_st.prdata  = 32'h0;
      next_st.pslverr = !aligned;
      if (aligned) begin
        unique case (idx)
          IDX_EVENT_FLAGS: next_st.prdata = {30'h0, st.flags};
          IDX_EVENT_MASKS: next_st.prdata = {30'h0, st.masks};
          IDX_HUNDREDTHS:  next_st.prdata = {28'h0, hund};
          IDX_TENTHS:      next_st.prdata = {28'h0, tenths};
          IDX_CONTROL:     next_st.prdata = {31'h0, st.run};
          IDX_IRQ_STATUS:  next_st.prdata = {30'h0, st.irq_status};
          default:         next_st.pslverr = 1'b1;
        endcase
      end
    end

    next_st.tenths_irq  = next_st.flags[BIT_TENTHS_EVENT]
                          && next_st.masks[BIT_TENTHS_EVENT];
    next_st.seconds_irq = next_st.flags[BIT_SECONDS_EVENT]
                          && next_st.masks[BIT_SECONDS_EVENT];
    next_st.irq         = |(next_st.irq_status & next_st.masks);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st            <= '0;
      st.flags      <= RST_FLAGS;
      st.masks      <= RST_MASKS;
      st.irq_status <= RST_IRQ_STATUS;
      st.run        <= RST_RUN;
    end else begin
      st <= next_st;
    end
  end

  assign o_prdata      = st.prdata;
  assign o_pready      = st.pready;
  assign o_pslverr     = st.pslverr;
  assign o_tenths_irq  = st.tenths_irq;
  assign o_seconds_irq = st.seconds_irq;
  assign o_irq         = st.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // running ticks since the last hundredths wrap
  logic [5:0] iv_ticks;
  logic       iv_valid;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      iv_ticks <= 6'h0;
      iv_valid <= 1'b0;
    end else if (clear) begin
      iv_ticks <= 6'h0;
      iv_valid <= 1'b0;
    end else if (hund_wrap) begin
      iv_ticks <= 6'h0;
      iv_valid <= 1'b1;
    end else if (tick && st.run) begin
      iv_ticks <= iv_ticks + 6'h1;
    end
  end

  // ticks since the last hundredths step; a halt keeps the partial count
  logic [1:0] step_ticks;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_ticks <= 2'h0;
    end else if (clear || hund_inc) begin
      step_ticks <= 2'h0;
    end else if (tick && st.run) begin
      step_ticks <= step_ticks + 2'h1;
    end
  end

  property p_digit_range;
    (hund <= DIGIT_MAX) && (tenths <= DIGIT_MAX);
  endproperty
  a_digit_range: assert property (p_digit_range) else $error("digit out of bcd range");

  property p_step_cause;
    ($changed(hund) && !$past(clear)) |-> ($past(tick) && $past(st.run));
  endproperty
  a_step_cause: assert property (p_step_cause) else $error("hundredths moved off a tick");

  property p_iv_len;
    (hund_wrap && iv_valid) |-> ((iv_ticks + 6'h1 == IV_SHORT) || (iv_ticks + 6'h1 == IV_LONG));
  endproperty
  a_iv_len: assert property (p_iv_len) else $error("tenths interval not 25 or 26");

  property p_wrap_flag;
    hund_wrap |=> st.flags[BIT_TENTHS_EVENT];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap left tenths flag clear");

  property p_sec_flag;
    tenths_wrap |=> st.flags[BIT_SECONDS_EVENT] ##1 (st.flags[BIT_SECONDS_EVENT] || $past(rd));
  endproperty
  a_sec_flag: assert property (p_sec_flag) else $error("seconds flag not set");

  property p_irq_follows;
    (o_tenths_irq == (st.flags[0] && st.masks[0]))
      && (o_seconds_irq == (st.flags[1] && st.masks[1]));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("event irq mismatch");

  property p_flag_write;
    (wr && (idx == IDX_EVENT_FLAGS) && !hund_wrap && !tenths_wrap)
      |=> (st.flags == $past(st.flags));
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write had effect");

  property p_clear;
    clear |=> (hund == 4'h0) && (tenths == 4'h0) && (st.run == $past(i_pwdata[BIT_RUN]));
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero digits");

  property p_halt;
    (!st.run && !clear) |=> $stable(hund) && $stable(tenths);
  endproperty
  a_halt: assert property (p_halt) else $error("digits moved while stopped");

  property p_digit_read;
    (setup && aligned && (idx == IDX_TENTHS))
      |=> (o_prdata == {28'h0, $past(tenths)}) && o_pready;
  endproperty
  a_digit_read: assert property (p_digit_read) else $error("tenths readback wrong");

  property p_read_clear;
    (rd && (idx == IDX_EVENT_FLAGS) && o_prdata[0] && !hund_wrap) |=> !st.flags[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag read did not clear");

  property p_step_len;
    hund_inc |-> ((step_ticks == 2'h1) || (step_ticks == 2'h2));
  endproperty
  a_step_len: assert property (p_step_len) else $error("step spacing not 2 or 3 ticks");

  property p_iv_pattern;
    (hund_wrap && iv_valid) |-> ((iv_ticks + 6'h1 == IV_LONG) == LONG_IV_MAP[tenths]);
  endproperty
  a_iv_pattern: assert property (p_iv_pattern) else $error("long interval out of place");

  property p_sec_cause;
    tenths_wrap |-> (hund_wrap && (tenths == DIGIT_MAX));
  endproperty
  a_sec_cause: assert property (p_sec_cause) else $error("tenths wrap without carry");

  property p_mask_write;
    (wr && aligned && (idx == IDX_EVENT_MASKS)) |=> (st.masks == $past(i_pwdata[1:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_run_write;
    (wr && aligned && (idx == IDX_CONTROL)) |=> (st.run == $past(i_pwdata[BIT_RUN]));
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bit write lost");

  property p_ctl_read;
    (setup && aligned && (idx == IDX_CONTROL)) |=> (o_prdata == {31'h0, $past(st.run)});
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");

  property p_flag_read;
    (setup && aligned && (idx == IDX_EVENT_FLAGS)) |=> (o_prdata == {30'h0, $past(st.flags)});
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");

  property p_pready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready held past one cycle");

  // ---------------------------------------------------------------
  // coverage of the main scenarios
  // ---------------------------------------------------------------
  c_hund_wrap:   cover property (hund_wrap);
  c_tenths_wrap: cover property (tenths_wrap);
  c_clear_run:   cover property (clear && st.run);
  c_irq:         cover property ($rose(o_irq));
  c_sec_irq:     cover property ($rose(o_seconds_irq));

endmodule : swt_stopwatch

/* swt_apb_master.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// apb master standing in for the processor core
// ---------------------------------------------------------------
module swt_apb_master (
  input  wire logic        i_mclk,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [15:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 16'h0000;
    o_pwdata  = 32'h0000_0000;
  end

  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge i_mclk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    do @(posedge i_mclk); while (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // released lines carry the inverse so a stale value never looks live
    o_paddr   <= ~a;
    o_pwdata  <= ~d;
  endtask : xfer
endmodule : swt_apb_master

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import swt_pkg::*;
();
  localparam logic [15:0] A_FLG = {IDX_EVENT_FLAGS, 2'b00};
  localparam logic [15:0] A_MSK = {IDX_EVENT_MASKS, 2'b00};
  localparam logic [15:0] A_HUN = {IDX_HUNDREDTHS, 2'b00};
  localparam logic [15:0] A_TEN = {IDX_TENTHS, 2'b00};
  localparam logic [15:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [15:0] A_IRQ = {IDX_IRQ_STATUS, 2'b00};
  logic        i_mclk, i_rst_n, psel, penable, pwrite, pready, pslverr;
  logic        t_irq, s_irq, irq, prev_t, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdata, d, h0, t0;
  int          mismatches, check_count, cyc, n_rise, base, longs;
  int          rise_t [0:63];
  integer      seed;

  swt_apb_master i_bus (.i_mclk(i_mclk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));
  swt_stopwatch #(.TICK_DIV(4)) i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_tenths_irq(t_irq), .o_seconds_irq(s_irq), .o_irq(irq));

  task automatic results();
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    i_bus.xfer(1'b1, a, v, rdata, err);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    i_bus.xfer(1'b0, a, 32'h0, rdata, err);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : idle

  // ---------------------------------------------------------------
  // clock, tenths-irq edge log, timeout
  // ---------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    prev_t <= t_irq;
    if (t_irq === 1'b1 && prev_t === 1'b0) begin
      rise_t[n_rise % 64] <= cyc;
      n_rise <= n_rise + 1;
    end
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    seed = 32'h46e1474f;
    i_rst_n = 1'b0;
    cyc = 0;
    n_rise = 0;
    prev_t = 1'b0;
    idle(10);
    i_rst_n <= 1'b1;
    rd(A_FLG); chk("flags_rst", 32'h0, rdata);
    rd(A_MSK); chk("masks_rst", 32'h0, rdata);
    rd(A_CTL); chk("ctl_rst", 32'h0, rdata);
    rd(A_HUN); chk("hun_rst", 32'h0, rdata);
    rd(A_TEN); chk("ten_rst", 32'h0, rdata);
    rd(16'h3c00); chk("unmapped_err", 32'h1, 32'(err));
    rd(A_MSK | 16'h0001); chk("unaligned_err", 32'h1, 32'(err));
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(A_FLG, d); rd(A_FLG); chk("flags_ro", 32'h0, rdata);
      wr(A_HUN, d); rd(A_HUN); chk("hun_ro", 32'h0, rdata);
      wr(A_MSK, d); rd(A_MSK); chk("masks_rw", d & 32'h3, rdata);
      wr(A_CTL, d | 32'h2); rd(A_CTL); chk("ctl_rd", d & 32'h1, rdata);
      // stop and clear so the next pass still sees zero digits
      wr(A_CTL, 32'h2);
    end
    wr(A_CTL, 32'h2); idle(100);
    rd(A_HUN); chk("hun_clr_stop", 32'h0, rdata);
    rd(A_TEN); chk("ten_clr_stop", 32'h0, rdata);
    // masked events: flags still set, no request
    wr(A_MSK, 32'h0); rd(A_FLG); wr(A_IRQ, 32'h3);
    wr(A_CTL, 32'h1); idle(130); wr(A_CTL, 32'h0);
    chk("tirq_masked", 32'h0, 32'(t_irq));
    chk("irq_masked", 32'h0, 32'(irq));
    rd(A_FLG); chk("flag_unmasked_set", 32'h1, rdata & 32'h1);
    rd(A_FLG); chk("flag_read_clear", 32'h0, rdata);
    wr(A_MSK, 32'h1); idle(2); chk("irq_on", 32'h1, 32'(irq));
    wr(A_IRQ, 32'h3); idle(2); chk("irq_off", 32'h0, 32'(irq));
    // stop holds the digits; software stops to read both coherently
    rd(A_HUN); h0 = rdata; rd(A_TEN); t0 = rdata;
    idle(200);
    rd(A_HUN); chk("hun_hold", h0, rdata);
    rd(A_TEN); chk("ten_hold", t0, rdata);
    chk("ten_moved", 32'h1, 32'(t0 >= 32'h1));
    // count pattern, measured on the tenths request edges
    wr(A_MSK, 32'h3); rd(A_FLG);
    base = n_rise;
    wr(A_CTL, 32'h3);
    longs = 0;
    for (int k = 1; k <= 11; k++) begin
      while (n_rise < base + k) @(posedge i_mclk);
      chk("sec_irq", 32'(k % 10 == 0), 32'(s_irq));
      rd(A_FLG); chk("flags_evt", (k % 10 == 0) ? 32'h3 : 32'h1, rdata);
    end
    for (int k = 1; k <= 10; k++) begin
      d = rise_t[(base + k) % 64] - rise_t[(base + k - 1) % 64];
      longs += (d == 104);
      chk("iv_len", LONG_IV_MAP[k % 10] ? 32'd104 : 32'd100, d);
    end
    chk("long_count", 32'd6, 32'(longs));
    for (int i = 0; i < 20; i++) begin
      idle($unsigned($random(seed)) % 64);
      rd(A_HUN); chk("hun_bcd", 32'h1, 32'(rdata <= 32'h9));
      rd(A_TEN); chk("ten_bcd", 32'h1, 32'(rdata <= 32'h9));
    end
    results();
  end
endmodule : tb_top
